// >>> dv/oamd_checker.sv
// Assertions on the executor ports
module oamd_checker (
    input wire logic CLK, // Clock
    input wire logic SRST, // Reset
    input wire oamd_pkg::oamd_instr_type INSTR, // Word
    input wire logic READY, // Decode
    input wire logic [7:0] FILE_RDATA, // Data
    input wire oamd_pkg::oamd_file_req_type FILE_REQ, // Access
    input wire logic [7:0] ACC, // Acc
    input wire logic ZERO, // Zero
    input wire logic DONE // Retire
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire t = READY && INSTR.valid;
    wire [13:0] w = INSTR.word;
    property p_rd; t && w[13:8] inside {6'h04, 6'h08} |=> FILE_REQ.rd; endproperty
    a_rd: assert property (p_rd) else $error("no read");
    property p_ph; t |=> !READY [*3] ##1 READY; endproperty
    a_ph: assert property (p_ph) else $error("phase count");
    property p_oa; t && w[13:7] == 7'h08 |-> ##4
        ACC == ($past(ACC, 4) | $past(FILE_RDATA, 3)); endproperty
    a_oa: assert property (p_oa) else $error("or to acc");
    property p_oz; t && w[13:8] == 6'h04 |-> ##4
        ZERO == (($past(ACC, 4) | $past(FILE_RDATA, 3)) == 8'h00); endproperty
    a_oz: assert property (p_oz) else $error("or zero");
    property p_ow; t && w[13:7] == 7'h09 |-> ##4 FILE_REQ.wr &&
        FILE_REQ.wdata == ($past(ACC, 4) | $past(FILE_RDATA, 3)); endproperty
    a_ow: assert property (p_ow) else $error("or to reg");
    property p_ca; t && w[13:7] == 7'h10 |-> ##4 DONE && ACC == $past(FILE_RDATA, 3); endproperty
    a_ca: assert property (p_ca) else $error("copy to acc");
    property p_cw; t && w[13:7] == 7'h11 |-> ##4 FILE_REQ.wdata == $past(FILE_RDATA, 3)
        && ZERO == ($past(FILE_RDATA, 3) == 8'h00); endproperty
    a_cw: assert property (p_cw) else $error("copy to reg");
    property p_ld; t && w[13:10] == 4'hc |-> ##4 ACC == $past(w[7:0], 4) && $stable(ZERO); endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_wa; t && w[13:7] inside {7'h09, 7'h11} |-> ##4 FILE_REQ.wr
        && FILE_REQ.addr == $past(w[6:0], 4); endproperty
    a_wa: assert property (p_wa) else $error("write address");
    property p_nd; t && !(w[13:8] inside {6'h04, 6'h08}) && w[13:10] != 4'hc
        |-> ##4 !DONE && !FILE_REQ.wr; endproperty
    a_nd: assert property (p_nd) else $error("unknown word retired");
    cover property (t && w[13:7] == 7'h09);
    cover property (t && w[13:7] == 7'h11);
    cover property (t && w[13:10] == 4'hc);
endmodule : oamd_checker
bind oamd_core oamd_checker u_chk (.CLK, .SRST, .INSTR, .READY, .FILE_RDATA,
    .FILE_REQ, .ACC, .ZERO, .DONE);

// >>> dv/oamd_core_test.sv
// Random and corner bench for the executor
module oamd_core_test;
    timeunit 1ns / 1ns;
    logic CLK = 0, SRST = 1, READY, ZERO, DONE, ez = 0;
    logic [7:0] FILE_RDATA = 8'h00, ACC, ea = 8'h00, m;
    logic [15:0] lf = 16'h0029;
    logic [10:0] x;
    logic [8:0] eq;
    logic [26:0] er, gr;
    oamd_pkg::oamd_instr_type INSTR = '0;
    oamd_pkg::oamd_file_req_type FILE_REQ;
    int error_cnt = 0, cmp_count = 0;
    localparam logic [13:0] cw [5] = '{14'h3000, 14'h0405, 14'h0885, 14'h30ff, 14'h0500};
    localparam logic [5:0] op [4] = '{6'h04, 6'h08, 6'h30, 6'h0d};
    always #20 CLK = ~CLK;
    oamd_core dut (.CLK, .SRST, .INSTR, .READY, .FILE_RDATA, .FILE_REQ, .ACC, .ZERO, .DONE);
    function automatic logic [15:0] nxt(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    function automatic logic [10:0] calc(logic [13:0] w);
        logic o = w[13:8] == 6'h04, c = w[13:8] == 6'h08, l = w[13:10] == 4'hc;
        return {o | c | l, (o | c) & w[7], o | c, l ? w[7:0] : o ? ea | m : c ? m : ea};
    endfunction : calc
    task automatic chk_req(logic [8:0] e, logic [8:0] g);
        cmp_count++;
        if (e !== g) error_cnt++;
        if (e !== g) $display("CHECK FAILED ready rd addr exp %h got %h", e, g);
    endtask : chk_req
    task automatic chk_ret(logic [26:0] e, logic [26:0] g);
        cmp_count++;
        if (e !== g) error_cnt++;
        if (e !== g) $display("CHECK FAILED retire exp %h got %h", e, g);
    endtask : chk_ret
    task automatic tally_and_finish(int n);
        error_cnt += n;
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic run(logic [13:0] w);
        lf = nxt(lf);
        // Masking gives frequent zero results
        m = lf[7:0] & {8{lf[11]}};
        x = calc(w);
        eq = {1'b0, x[8], x[8] ? w[6:0] : 7'h00};
        @(posedge CLK) {INSTR, FILE_RDATA} <= {1'b1, w, m};
        @(posedge CLK) INSTR.valid <= 1'b0;
        #1 chk_req(eq, {READY, FILE_REQ.rd, FILE_REQ.addr});
        // Stale data after the read edge must not leak in
        @(posedge CLK) FILE_RDATA <= ~m;
        repeat (2) @(posedge CLK);
        #1 if (x[10] && !x[9]) ea = x[7:0];
        if (x[8]) ez = x[7:0] == 8'h00;
        er = {ea, ez, x[10], x[9], x[9] ? w[6:0] : 7'h00, x[9] ? x[7:0] : 8'h00, 1'b1};
        gr = {ACC, ZERO, DONE, FILE_REQ.wr, FILE_REQ.addr, FILE_REQ.wdata, READY};
        chk_ret(er, gr);
    endtask : run
    initial begin
        repeat (8) @(posedge CLK);
        SRST <= 1'b0;
        #1 gr = {ACC, ZERO, DONE, FILE_REQ.wr, FILE_REQ.addr, FILE_REQ.wdata, READY};
        chk_ret(27'h0000001, gr);
        foreach (cw[i]) run(cw[i]);
        repeat (40) run({op[lf[15:14]], lf[7:0]});
        tally_and_finish(0);
    end
    initial #40000 tally_and_finish(1);
endmodule : oamd_core_test

// >>> rtl/oamd_core.sv
// Four-phase executor for OR, load-immediate and copy instructions
module oamd_core (
    input  wire logic                       CLK,      // Core clock
    input  wire logic                       SRST,     // Sync reset, active high
    input  wire oamd_pkg::oamd_instr_type   INSTR,    // Instruction offered
    output logic                            READY,    // Taking a word at decode
    input  wire logic [oamd_pkg::DATA_W-1:0] FILE_RDATA, // Register read data
    output oamd_pkg::oamd_file_req_type     FILE_REQ, // Register file access
    output logic [oamd_pkg::DATA_W-1:0]     ACC,      // Accumulator
    output logic                            ZERO,     // Zero flag
    output logic                            DONE      // Pulse: instruction retired
);
    import oamd_pkg::*;

    // Fields of the offered word
    logic [1:0]          word_class;
    logic [3:0]          word_op;
    logic [1:0]          word_load_hi;
    logic                word_dest;
    logic [ADDR_W-1:0]   word_addr;
    logic [DATA_W-1:0]   word_literal;

    // Kind of the offered word
    logic                is_or;
    logic                is_copy;
    logic                is_load;
    logic                reads_file;
    oamd_op_type         word_kind;

    // Helpers for the phase being executed
    oamd_phase_type      phase_after;
    logic                touches_zero;
    logic                writes_file;
    logic                writes_acc;
    logic                retires;
    logic [DATA_W-1:0]   or_value;
    logic [DATA_W-1:0]   bits_seen;
    logic                result_zero;
    oamd_file_req_type   read_req;
    oamd_file_req_type   write_req;

    oamd_state_type      state;
    oamd_state_type      next_state;

    assign READY    = (state.phase == OAMD_PH_DECODE);
    assign FILE_REQ = state.req;
    assign ACC      = state.acc;
    assign ZERO     = state.zero;
    assign DONE     = state.done;

    assign word_class   = INSTR.word[CLASS_MSB:CLASS_LSB];
    assign word_op      = INSTR.word[OP_MSB:OP_LSB];
    assign word_load_hi = INSTR.word[OP_MSB:LOAD_LSB];
    assign word_dest    = INSTR.word[DEST_BIT];
    assign word_addr    = INSTR.word[ADDR_W-1:0];
    assign word_literal = INSTR.word[DATA_W-1:0];

    // The two low opcode bits of a load never reach a compare
    assign is_or      = (word_class == CLASS_BYTE) && (word_op == OP_OR);
    assign is_copy    = (word_class == CLASS_BYTE) && (word_op == OP_COPY);
    assign is_load    = (word_class == CLASS_LITERAL) && (word_load_hi == OP_LOAD_HI);
    assign reads_file = is_or || is_copy;

    always_comb begin
        if (is_or) begin
            word_kind = OAMD_OP_OR;
        end else if (is_copy) begin
            word_kind = OAMD_OP_COPY;
        end else if (is_load) begin
            word_kind = OAMD_OP_LOAD;
        end else begin
            // Unknown words still take four phases but change nothing
            word_kind = OAMD_OP_NONE;
        end
    end

    // Fixed walk through the four phases, one per clock
    always_comb begin
        unique case (state.phase)
            OAMD_PH_DECODE: begin
                phase_after = OAMD_PH_READ;
            end
            OAMD_PH_READ: begin
                phase_after = OAMD_PH_PROCESS;
            end
            OAMD_PH_PROCESS: begin
                phase_after = OAMD_PH_WRITE;
            end
            OAMD_PH_WRITE: begin
                phase_after = OAMD_PH_DECODE;
            end
        endcase
    end

    always_comb begin
        read_req      = '0;
        read_req.rd   = reads_file;
        read_req.addr = word_addr;
    end

    always_comb begin
        write_req       = '0;
        write_req.wr    = writes_file;
        write_req.addr  = state.addr;
        write_req.wdata = state.result;
    end

    // One OR lane per data bit
    for (genvar lane = 0; lane < DATA_W; lane++) begin : g_or_lane
        assign or_value[lane] = state.acc[lane] | state.operand[lane];
    end

    // Ripple of set bits; the last stage is low only for an all-zero result
    assign bits_seen[0] = state.result[0];
    for (genvar b = 1; b < DATA_W; b++) begin : g_zero
        assign bits_seen[b] = bits_seen[b-1] | state.result[b];
    end
    assign result_zero = ~bits_seen[DATA_W-1];

    assign touches_zero = (state.op == OAMD_OP_OR) || (state.op == OAMD_OP_COPY);
    assign writes_file  = touches_zero && state.to_reg;
    assign writes_acc   = (touches_zero && !state.to_reg)
                          || (state.op == OAMD_OP_LOAD);
    assign retires      = (state.op != OAMD_OP_NONE);

    // One pass per phase; the copy holds whatever a phase leaves alone, except done and req, which clear every cycle
    always_comb begin
        next_state      = state;
        next_state.done = 1'b0;
        next_state.req  = '0;

        unique case (state.phase)
            OAMD_PH_DECODE: begin
                // Phases only advance with a word so an idle core stays at decode
                next_state.op   = OAMD_OP_NONE;
                next_state.busy = 1'b0;
                if (INSTR.valid) begin
                    next_state.busy    = 1'b1;
                    next_state.phase   = phase_after;
                    next_state.op      = word_kind;
                    next_state.to_reg  = word_dest;
                    next_state.addr    = word_addr;
                    // A literal parks in the operand until the process phase
                    next_state.operand = word_literal;
                    if (reads_file) begin
                        next_state.req = read_req;
                    end
                end
            end

            OAMD_PH_READ: begin
                // Register data is taken in the same cycle as the read strobe
                if (touches_zero) begin
                    next_state.operand = FILE_RDATA;
                end
                next_state.phase = phase_after;
            end

            OAMD_PH_PROCESS: begin
                unique case (state.op)
                    OAMD_OP_OR: begin
                        next_state.result = or_value;
                    end
                    OAMD_OP_COPY: begin
                        next_state.result = state.operand;
                    end
                    OAMD_OP_LOAD: begin
                        next_state.result = state.operand;
                    end
                    OAMD_OP_NONE: begin
                        next_state.result = state.result;
                    end
                endcase
                next_state.phase = phase_after;
            end

            OAMD_PH_WRITE: begin
                // Load leaves the zero flag alone
                if (touches_zero) begin
                    next_state.zero = result_zero;
                end
                if (writes_file) begin
                    // Copy rewrites the same value: contents unchanged
                    next_state.req = write_req;
                end
                if (writes_acc) begin
                    next_state.acc = state.result;
                end
                next_state.done  = retires;
                next_state.busy  = 1'b0;
                next_state.phase = phase_after;
            end
        endcase
    end

    // Reset parks the core at decode so a word may follow at once
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state       <= '0;
            state.phase <= OAMD_PH_DECODE;
            state.acc   <= ACC_RESET;
        end else begin
            state <= next_state;
        end
    end
endmodule : oamd_core

// >>> rtl/oamd_pkg.sv
// Package for the OR / load / copy instruction decoder
package oamd_pkg;
    localparam int INSTR_W    = 14;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 7;
    // Field positions inside an instruction word
    localparam int CLASS_MSB  = 13;
    localparam int CLASS_LSB  = 12;
    localparam int OP_MSB     = 11;
    localparam int OP_LSB     = 8;
    localparam int LOAD_LSB   = 10;
    localparam int DEST_BIT   = 7;
    // Opcode fields
    localparam logic [1:0] CLASS_BYTE    = 2'h0;
    localparam logic [1:0] CLASS_LITERAL = 2'h3;
    localparam logic [3:0] OP_OR         = 4'h4;
    localparam logic [3:0] OP_COPY       = 4'h8;
    localparam logic [1:0] OP_LOAD_HI    = 2'h0;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

    typedef enum logic [1:0] {
        OAMD_PH_DECODE  = 2'b00,
        OAMD_PH_READ    = 2'b01,
        OAMD_PH_PROCESS = 2'b10,
        OAMD_PH_WRITE   = 2'b11
    } oamd_phase_type;

    typedef enum logic [1:0] {
        OAMD_OP_NONE = 2'b00,
        OAMD_OP_OR   = 2'b01,
        OAMD_OP_LOAD = 2'b10,
        OAMD_OP_COPY = 2'b11
    } oamd_op_type;

    typedef struct packed {
        logic              valid;
        logic [INSTR_W-1:0] word;
    } oamd_instr_type;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } oamd_file_req_type;

    typedef struct packed {
        oamd_phase_type     phase;
        oamd_op_type        op;
        logic               to_reg;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  operand;
        logic [DATA_W-1:0]  result;
        logic [DATA_W-1:0]  acc;
        logic               zero;
        logic               busy;
        logic               done;
        oamd_file_req_type  req;
    } oamd_state_type;
endpackage : oamd_pkg
